/* hw/cal_pattern_pkg.sv */
// package: constants, types and helpers for the calibration pattern readout
package cal_pattern_pkg;

  localparam int          DQ_WIDTH_DEF  = 16;
  localparam int          BYTE_W        = 8;
  localparam int          MIN_RL        = 3;
  localparam int          MAX_RL_DEF    = 32;
  localparam int          RL_W          = 5;
  localparam logic [2:0]  BA_MODE_THREE = 3'h3;
  localparam int          ENABLE_BIT    = 2;
  localparam int          LOC_LSB       = 0;
  localparam int          HALF_BIT      = 2;
  localparam int          CHOP_BIT      = 12;
  localparam logic        ENABLE_RST    = 1'h0;
  localparam logic [1:0]  LOC_RST       = 2'h0;
  localparam logic [1:0]  LOC_CAL       = 2'h0;
  localparam logic [7:0]  PATTERN_CAL   = 8'haa;
  localparam logic [7:0]  PATTERN_RSV   = 8'h00;
  localparam logic [2:0]  LEFT_BL8      = 3'h7;
  localparam logic [2:0]  LEFT_BC4      = 3'h3;
  localparam logic [2:0]  POS_LOWER     = 3'h0;
  localparam logic [2:0]  POS_UPPER     = 3'h4;

  // encoding of the burst length field of mode_register_zero
  typedef enum logic [1:0] {
    BURST_FIXED_8 = 2'h0,
    BURST_ON_FLY  = 2'h1,
    BURST_FIXED_4 = 2'h2
  } burst_mode_e;

  typedef enum logic [2:0] {CMD_NONE, CMD_MRS, CMD_READ, CMD_WRITE, CMD_OTHER} cmd_kind_e;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [15:0] addr;
  } cmd_s;

  typedef struct packed {
    cmd_kind_e   kind;
    logic [2:0]  ba;
    logic [15:0] addr;
  } array_cmd_s;

  typedef struct packed {
    logic       valid;
    logic       chop;
    logic       upper;
    logic [1:0] loc;
  } pattern_req_s;

  function automatic cmd_kind_e decode_cmd(input cmd_s c);
    cmd_kind_e k;
    k = CMD_NONE;
    if (!c.cs_n) begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h0:    k = CMD_MRS;
        3'h5:    k = CMD_READ;
        3'h4:    k = CMD_WRITE;
        3'h7:    k = CMD_NONE;
        default: k = CMD_OTHER;
      endcase
    end
    return k;
  endfunction

  function automatic logic chop_of(input burst_mode_e m, input logic a12);
    logic c;
    case (m)
      BURST_FIXED_4: c = 1'h1;
      BURST_ON_FLY:  c = !a12;
      default:       c = 1'h0;
    endcase
    return c;
  endfunction

  // reserved locations read back as zeros
  function automatic logic [7:0] pattern_of(input logic [1:0] loc);
    return (loc == LOC_CAL) ? PATTERN_CAL : PATTERN_RSV;
  endfunction

  function automatic logic [BYTE_W-1:0] lane_fill(input logic b, input logic repl);
    return {{(BYTE_W-1){repl & b}}, b};
  endfunction

endpackage

/* hw/pattern_burst_gen.sv */
// pattern burst generator: walks one calibration pattern burst beat by beat
`timescale 1ns/100ps
module pattern_burst_gen (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire cal_pattern_pkg::pattern_req_s i_req,
  output logic                             o_beat_valid,
  output logic                             o_beat_bit
);

  typedef enum logic {GEN_IDLE, GEN_BURST} gen_state_e;

  gen_state_e state_reg;
  logic [7:0] pattern_reg;
  logic [2:0] pos_reg;
  logic [2:0] left_reg;
  logic [7:0] start_pattern;
  logic [2:0] start_pos;

  assign start_pattern = cal_pattern_pkg::pattern_of(i_req.loc);
  assign start_pos     = i_req.upper ? cal_pattern_pkg::POS_UPPER : cal_pattern_pkg::POS_LOWER;

  // a new request restarts the walk; the controller keeps bursts apart
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= GEN_IDLE;
      pattern_reg <= 8'h00;
      pos_reg     <= 3'h0;
      left_reg    <= 3'h0;
    end else if (i_req.valid) begin
      state_reg   <= GEN_BURST;
      pattern_reg <= start_pattern;
      pos_reg     <= start_pos + 3'h1;
      left_reg    <= i_req.chop ? cal_pattern_pkg::LEFT_BC4 : cal_pattern_pkg::LEFT_BL8;
    end else begin
      case (state_reg)
        GEN_BURST: begin
          pos_reg  <= pos_reg + 3'h1;
          left_reg <= left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            state_reg <= GEN_IDLE;
          end
        end
        default: state_reg <= GEN_IDLE;
      endcase
    end
  end

  // position 0 is the lsb of the pattern
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_beat_valid <= 1'h0;
      o_beat_bit   <= 1'h0;
    end else if (i_req.valid) begin
      o_beat_valid <= 1'h1;
      o_beat_bit   <= start_pattern[start_pos];
    end else begin
      o_beat_valid <= (state_reg == GEN_BURST);
      o_beat_bit   <= (state_reg == GEN_BURST) ? pattern_reg[pos_reg] : 1'h0;
    end
  end

  default clocking gen_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_cal_start;
    i_req.valid && (i_req.loc == cal_pattern_pkg::LOC_CAL) ##1 !i_req.valid;
  endsequence

  chk_bl8_length: assert property (i_req.valid && !i_req.chop |=> o_beat_valid[*8])
    else $error("eight-beat burst shorter than eight beats");
  chk_bc4_length: assert property (i_req.valid && i_req.chop |=> o_beat_valid[*4])
    else $error("chopped burst shorter than four beats");
  chk_cal_beats: assert property (s_cal_start |-> !o_beat_bit ##1 o_beat_bit)
    else $error("calibration pattern does not open with 0 then 1");

endmodule

/* hw/sdram_calibration_pattern_readout.sv */
// pattern readout mode of a x16 sdram: mode register three and pattern reads
`timescale 1ns/100ps

module sdram_calibration_pattern_readout #(
  parameter int DQ_WIDTH  = cal_pattern_pkg::DQ_WIDTH_DEF,
  parameter int MAX_RL    = cal_pattern_pkg::MAX_RL_DEF,
  parameter bit REPLICATE = 1'b1
) (
  input  wire logic                                      i_clk,
  input  wire logic                                      i_rst_n,
  input  wire cal_pattern_pkg::cmd_s                     i_cmd,
  input  wire cal_pattern_pkg::burst_mode_e              i_burst_mode,
  input  wire logic [cal_pattern_pkg::RL_W-1:0]          i_read_latency,
  input  wire logic [DQ_WIDTH-1:0]                       i_array_dq,
  input  wire logic                                      i_array_dq_oe,
  output logic                                           o_array_cmd_valid,
  output cal_pattern_pkg::array_cmd_s                    o_array_cmd,
  output logic [DQ_WIDTH-1:0]                            o_dq,
  output logic                                           o_dq_oe,
  output logic                                           o_pattern_beat,
  output logic                                           o_mode_enable,
  output logic [1:0]                                     o_location
);

  localparam int LANES = DQ_WIDTH / cal_pattern_pkg::BYTE_W;
  localparam int TAP_W = (MAX_RL > 1) ? $clog2(MAX_RL) : 1;

  if (DQ_WIDTH != 8 && DQ_WIDTH != 16) begin : g_bad_width
    $error("DQ_WIDTH must be 8 or 16");
  end
  if (MAX_RL < cal_pattern_pkg::MIN_RL) begin : g_bad_rl
    $error("MAX_RL below the least read latency this pipeline serves");
  end

  logic [1:0]                      rst_pipe_reg;
  logic                            rst_n_sync;
  cal_pattern_pkg::cmd_kind_e      cmd_kind;
  logic                            mode_write;
  logic                            is_read;
  logic                            pattern_read;
  logic                            enable_reg;
  logic [1:0]                      loc_reg;
  cal_pattern_pkg::pattern_req_s   req_in;
  cal_pattern_pkg::pattern_req_s   req_line [MAX_RL];
  logic [TAP_W-1:0]                tap;
  logic                            beat_valid;
  logic                            beat_bit;
  logic [DQ_WIDTH-1:0]             pattern_dq;

  // reset asserts at once and releases two edges later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'h1};
    end
  end

  assign rst_n_sync = rst_pipe_reg[1];

  // command decode; only cs/ras/cas/we and the bank field matter here
  assign cmd_kind     = cal_pattern_pkg::decode_cmd(i_cmd);
  assign mode_write   = (cmd_kind == cal_pattern_pkg::CMD_MRS) &&
                        (i_cmd.ba == cal_pattern_pkg::BA_MODE_THREE);
  assign is_read      = (cmd_kind == cal_pattern_pkg::CMD_READ);
  assign pattern_read = is_read && enable_reg;

  // mode_register_three: enable bit and pattern_location_field
  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      enable_reg <= cal_pattern_pkg::ENABLE_RST;
      loc_reg    <= cal_pattern_pkg::LOC_RST;
    end else if (mode_write) begin
      enable_reg <= i_cmd.addr[cal_pattern_pkg::ENABLE_BIT];
      loc_reg    <= i_cmd.addr[cal_pattern_pkg::LOC_LSB +: 2];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_mode_enable <= cal_pattern_pkg::ENABLE_RST;
      o_location    <= cal_pattern_pkg::LOC_RST;
    end else begin
      o_mode_enable <= enable_reg;
      o_location    <= loc_reg;
    end
  end

  // bank bits, A10 and the upper column bits never reach the request
  always_comb begin
    req_in.valid = pattern_read;
    req_in.chop  = cal_pattern_pkg::chop_of(i_burst_mode,
                                            i_cmd.addr[cal_pattern_pkg::CHOP_BIT]);
    // eight-beat bursts always start at beat 0, chopped ones pick a half
    req_in.upper = req_in.chop & i_cmd.addr[cal_pattern_pkg::HALF_BIT];
    req_in.loc   = loc_reg;
  end

  // read latency line; its tap lines the first beat up with array reads
  function automatic logic [TAP_W-1:0] tap_of(input logic [cal_pattern_pkg::RL_W-1:0] rl);
    int t;
    t = int'(rl) - cal_pattern_pkg::MIN_RL;
    if (t < 0) begin
      t = 0;
    end
    if (t > MAX_RL - 1) begin
      t = MAX_RL - 1;
    end
    return TAP_W'(t);
  endfunction

  assign tap = tap_of(i_read_latency);

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      for (int k = 0; k < MAX_RL; k++) begin
        req_line[k] <= '0;
      end
    end else begin
      req_line[0] <= req_in;
      for (int k = 1; k < MAX_RL; k++) begin
        req_line[k] <= req_line[k-1];
      end
    end
  end

  pattern_burst_gen u_gen (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n_sync),
    .i_req        (req_line[tap]),
    .o_beat_valid (beat_valid),
    .o_beat_bit   (beat_bit)
  );

  // every byte lane carries the same one-bit stream
  for (genvar b = 0; b < LANES; b++) begin : g_lane
    assign pattern_dq[b*cal_pattern_pkg::BYTE_W +: cal_pattern_pkg::BYTE_W] =
      cal_pattern_pkg::lane_fill(beat_bit, REPLICATE);
  end

  // data pins: pattern beats take the bus, otherwise array data passes
  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_dq           <= '0;
      o_dq_oe        <= 1'h0;
      o_pattern_beat <= 1'h0;
    end else begin
      o_dq           <= beat_valid ? pattern_dq : i_array_dq;
      o_dq_oe        <= beat_valid | i_array_dq_oe;
      o_pattern_beat <= beat_valid;
    end
  end

  // commands for the array; pattern reads never reach it, so an
  // autoprecharge on them is dropped with the rest of the command
  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_array_cmd_valid <= 1'h0;
      o_array_cmd       <= '0;
    end else begin
      o_array_cmd_valid <= (cmd_kind != cal_pattern_pkg::CMD_NONE) &&
                           !pattern_read && !mode_write;
      o_array_cmd.kind  <= cmd_kind;
      o_array_cmd.ba    <= i_cmd.ba;
      o_array_cmd.addr  <= i_cmd.addr;
    end
  end

  default clocking main_cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n_sync);

  sequence s_read_in_mode;
    is_read && enable_reg;
  endsequence

  sequence s_read_normal;
    is_read && !enable_reg && !mode_write;
  endsequence

  chk_mode_capture: assert property (mode_write |=>
      enable_reg == $past(i_cmd.addr[2]) && loc_reg == $past(i_cmd.addr[1:0]))
    else $error("mode register three did not take the written fields");

  chk_pattern_redirect: assert property (s_read_in_mode |=>
      !o_array_cmd_valid && req_line[0].valid)
    else $error("read in pattern mode reached the array");

  chk_normal_forward: assert property (s_read_normal |=>
      o_array_cmd_valid && !req_line[0].valid)
    else $error("normal read not passed to the array");

  chk_autopre_drop: assert property (s_read_in_mode ##0 i_cmd.addr[10] |=>
      !o_array_cmd_valid)
    else $error("autoprecharge issued for a pattern read");

  chk_chop_select: assert property (s_read_in_mode ##0
      i_burst_mode == cal_pattern_pkg::BURST_ON_FLY |=>
      req_line[0].chop == !$past(i_cmd.addr[12]))
    else $error("on-the-fly chop not taken from A12");

  chk_half_select: assert property (s_read_in_mode ##0
      i_burst_mode == cal_pattern_pkg::BURST_FIXED_4 |=>
      req_line[0].upper == $past(i_cmd.addr[2]))
    else $error("chopped half not taken from A2");

  chk_lane_copy: assert property (o_pattern_beat |->
      o_dq_oe && o_dq[DQ_WIDTH-1 -: 8] == o_dq[7:0] &&
      o_dq[7:1] == (REPLICATE ? {7{o_dq[0]}} : 7'h00))
    else $error("byte lanes do not carry the pattern bit");

  chk_latency_start: assert property (
      req_line[tap].valid && !$past(req_line[tap].valid) |=> ##1 o_pattern_beat)
    else $error("pattern burst did not start on the latency tap");

  // helper sequences for the data path and the forwarded command stream
  sequence s_beat_now;
    beat_valid;
  endsequence

  sequence s_write_normal;
    (cmd_kind == cal_pattern_pkg::CMD_WRITE) && !enable_reg;
  endsequence

  chk_beat_drive: assert property (s_beat_now |=>
      o_pattern_beat && o_dq_oe && o_dq == $past(pattern_dq))
    else $error("pattern beat not driven on the data pins");

  chk_array_pass: assert property (!beat_valid |=>
      o_dq == $past(i_array_dq) && o_dq_oe == $past(i_array_dq_oe))
    else $error("array data not passed while no pattern beat");

  chk_idle_quiet: assert property (!beat_valid |=> !o_pattern_beat)
    else $error("pattern beat flagged with no burst running");

  chk_mode_copy: assert property (1'b1 |=>
      o_mode_enable == $past(enable_reg) && o_location == $past(loc_reg))
    else $error("mode outputs do not follow mode register three");

  chk_mode_hold: assert property (!mode_write |=>
      $stable(enable_reg) && $stable(loc_reg))
    else $error("mode register three changed without a mode write");

  chk_mrs_local: assert property (mode_write |=> !o_array_cmd_valid)
    else $error("mode register three write reached the array");

  chk_ignored_bits: assert property (s_read_in_mode |=>
      req_line[0].loc == $past(loc_reg) &&
      req_line[0].upper == (req_line[0].chop & $past(i_cmd.addr[2])))
    else $error("ignored address bits changed the pattern request");

  chk_bl8_whole: assert property (s_read_in_mode ##0 !req_in.chop |=>
      !req_line[0].upper)
    else $error("eight-beat burst did not start at beat 0");

  chk_fixed_chop: assert property (s_read_in_mode ##0
      i_burst_mode == cal_pattern_pkg::BURST_FIXED_4 |=> req_line[0].chop)
    else $error("fixed chop mode did not chop the burst");

  chk_fixed_full: assert property (s_read_in_mode ##0
      i_burst_mode == cal_pattern_pkg::BURST_FIXED_8 |=> !req_line[0].chop)
    else $error("fixed eight-beat mode chopped the burst");

  chk_stage_clear: assert property (!pattern_read |=> !req_line[0].valid)
    else $error("pattern request raised without a read in mode");

  chk_write_forward: assert property (s_write_normal |=>
      o_array_cmd_valid && o_array_cmd.kind == cal_pattern_pkg::CMD_WRITE)
    else $error("write in normal mode not passed to the array");

  chk_cmd_kind: assert property (o_array_cmd_valid |->
      o_array_cmd.kind != cal_pattern_pkg::CMD_NONE)
    else $error("forwarded command carries no command");

endmodule

/* testbench/ctrl_model.sv */
// controller stand-in: forms mode register three writes and reads on the command bus
`timescale 1ns/100ps
module ctrl_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_go,
  input  wire logic                   i_mrs,
  input  wire logic                   i_wr,
  input  wire logic [2:0]             i_ba,
  input  wire logic [15:0]            i_addr,
  output cal_pattern_pkg::cmd_s       o_cmd
);
  logic [15:0] idle_reg = 16'h5a5a;

  // idle cycles carry nop with toggling address so a stale value never looks valid
  always @(posedge i_clk) begin
    idle_reg <= ~idle_reg;
  end

  // only mode writes, reads and writes are formed; banks idle and dll lock assumed from reset
  always_comb begin
    o_cmd = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
              ba: idle_reg[2:0], addr: idle_reg};
    if (i_go && i_mrs) begin
      o_cmd.ras_n = 1'b0;
      o_cmd.cas_n = 1'b0;
      o_cmd.we_n  = 1'b0;
      o_cmd.ba    = cal_pattern_pkg::BA_MODE_THREE;
      o_cmd.addr  = {13'h0, i_addr[2:0]};
    end else if (i_go) begin
      o_cmd.cas_n = 1'b0;
      o_cmd.we_n  = !i_wr;
      o_cmd.ba    = i_ba;
      o_cmd.addr  = {i_addr[15:2], 2'h0};
    end
  end
endmodule

/* testbench/testbench.sv */
// self-checking bench for the calibration pattern readout block
`timescale 1ns/100ps
module testbench;
  logic                         clk = 1'b0;
  logic                         rst_n;
  logic                         go;
  logic                         mrs;
  logic                         wr;
  logic [2:0]                   ba;
  logic [15:0]                  addr;
  logic [15:0]                  adq;
  logic                         adq_oe;
  int                           rl;
  cal_pattern_pkg::burst_mode_e bmode;
  cal_pattern_pkg::cmd_s        cmd;
  cal_pattern_pkg::array_cmd_s  o_array_cmd;
  logic                         o_array_cmd_valid;
  logic [15:0]                  o_dq;
  logic                         o_dq_oe;
  logic                         o_pattern_beat;
  logic                         o_mode_enable;
  logic [1:0]                   o_location;
  int                           mismatches = 0;
  int                           comparisons = 0;
  int                           seed = 32'hbb69cc48;

  always #2 clk = ~clk;

  ctrl_model u_ctrl (.i_clk(clk), .i_go(go), .i_mrs(mrs), .i_wr(wr), .i_ba(ba),
                     .i_addr(addr), .o_cmd(cmd));

  sdram_calibration_pattern_readout #(.DQ_WIDTH(16), .MAX_RL(8), .REPLICATE(1'b1)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd), .i_burst_mode(bmode),
    .i_read_latency(rl[4:0]), .i_array_dq(adq), .i_array_dq_oe(adq_oe),
    .o_array_cmd_valid(o_array_cmd_valid), .o_array_cmd(o_array_cmd), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_pattern_beat(o_pattern_beat), .o_mode_enable(o_mode_enable),
    .o_location(o_location));

  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // one command held for one cycle; returns in the cycle after it
  task automatic issue(input logic m, input logic [2:0] b, input logic [15:0] a);
    go   = 1'b1;
    mrs  = m;
    ba   = b;
    addr = a;
    tick();
    go   = 1'b0;
  endtask

  task automatic set_mode(input logic en, input logic [1:0] loc);
    issue(1'b1, 3'h0, {13'h0, en, loc});
    check(o_array_cmd_valid, 1'b0);
    tick();
    check(o_mode_enable, en);
    check(o_location, loc);
  endtask

  task automatic normal_read(input logic w);
    cal_pattern_pkg::array_cmd_s e;
    int r;
    r = $random(seed);
    e.kind = w ? cal_pattern_pkg::CMD_WRITE : cal_pattern_pkg::CMD_READ;
    e.ba   = r[2:0];
    e.addr = r[31:16] & 16'hfffc;
    adq    = r[15:0];
    adq_oe = 1'b1;
    wr     = w;
    issue(1'b0, e.ba, e.addr);
    wr     = 1'b0;
    check(o_array_cmd_valid, 1'b1);
    check(o_array_cmd, e);
    check(o_dq, r[15:0]);
    check(o_dq_oe, 1'b1);
    adq_oe = 1'b0;
    tick();
    check(o_array_cmd_valid, 1'b0);
  endtask

  // reference: queue of expected words built from location, start beat and count
  task automatic pread(input logic a12, input logic a2, input int nb, input int first,
                       input logic [1:0] loc);
    logic [15:0] q[$];
    logic [7:0]  b;
    int          k;
    int          r;
    for (k = 0; k < nb; k++) begin
      b = (loc == 2'h0 && ((first + k) % 2) == 1) ? 8'hff : 8'h00;
      q.push_back({b, b});
    end
    r   = $random(seed);
    adq = r[31:16];
    // random ignored address bits and bank, autoprecharge form
    issue(1'b0, r[2:0], (r[15:0] & 16'hebf8) | 16'h0400 | {3'h0, a12, 9'h0, a2, 2'h0});
    check(o_array_cmd_valid, 1'b0);
    for (k = 1; k < rl; k++)
      tick();
    while (q.size() > 0) begin
      check(o_pattern_beat, 1'b1);
      check(o_dq_oe, 1'b1);
      check(o_dq, q.pop_front());
      tick();
    end
    check(o_pattern_beat, 1'b0);
  endtask

  initial begin
    rst_n  = 1'b0;
    go     = 1'b0;
    mrs    = 1'b0;
    wr     = 1'b0;
    ba     = 3'h0;
    addr   = 16'h0;
    adq    = 16'h0;
    adq_oe = 1'b0;
    rl     = 5;
    bmode  = cal_pattern_pkg::BURST_FIXED_8;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    tick();
    tick();
    check(o_mode_enable, 1'b0);
    check(o_location, 2'h0);
    normal_read(1'b0);
    set_mode(1'b1, 2'h0);
    for (int i = 3; i <= 7; i += 2) begin
      rl = i;
      pread(1'b0, 1'b0, 8, 0, 2'h0);
    end
    bmode = cal_pattern_pkg::BURST_FIXED_4;
    pread(1'b1, 1'b0, 4, 0, 2'h0);
    pread(1'b1, 1'b1, 4, 4, 2'h0);
    bmode = cal_pattern_pkg::BURST_ON_FLY;
    pread(1'b1, 1'b0, 8, 0, 2'h0);
    pread(1'b0, 1'b1, 4, 4, 2'h0);
    bmode = cal_pattern_pkg::BURST_FIXED_8;
    for (int l = 1; l < 4; l++) begin
      set_mode(1'b1, l[1:0]);
      pread(1'b0, 1'b0, 8, 0, l[1:0]);
    end
    set_mode(1'b0, 2'h3);
    normal_read(1'b1);
    set_mode(1'b1, 2'h0);
    rst_n = 1'b0;
    #1;
    check(o_mode_enable, 1'b0);
    tick();
    rst_n = 1'b1;
    tick();
    tick();
    check(o_mode_enable, 1'b0);
    normal_read(1'b0);
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
